// File: dv/smr_link_assertions.sv
// Checker for the mode register link between both ends.
// Assumes one core clock and the link signals as plain inputs.
`timescale 1ns/1ps
module smr_link_assertions (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       reset_n,
  // Link
  input wire logic       cmdValid,
  input wire logic       cmdWrite,
  input wire logic [5:0] cmdAddr,
  input wire logic [7:0] cmdData,
  input wire logic       rdValid,
  input wire logic [7:0] rdData
);
  logic       rdCmd;
  logic [5:0] lastAddr_r;
  logic [7:0] lastData_r;

  assign rdCmd = cmdValid && !cmdWrite;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Last write seen on the link, for read-back checks.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lastAddr_r <= 6'h00;
      lastData_r <= 8'h00;
    end else if (cmdValid && cmdWrite) begin
      lastAddr_r <= cmdAddr;
      lastData_r <= cmdData;
    end
  end

  // ****
  // Properties
  // ****
  read_answer_a: assert property (rdCmd |=> rdValid)
    else $error("read not answered");
  answer_cause_a: assert property (rdValid |-> $past(rdCmd))
    else $error("answer without read");
  cmd_pulse_a: assert property (cmdValid && !cmdWrite |=> !cmdValid [*2])
    else $error("commands too close");
  write_pulse_a: assert property (cmdValid && cmdWrite |=> !cmdValid)
    else $error("write commands too close");
  idle_zero_a: assert property (!rdValid |-> rdData == 8'h00)
    else $error("read byte not idle");
  no_rsvd_write_a: assert property (cmdValid && cmdWrite |-> !(cmdAddr inside
    {6'h15, 6'h1E, 6'h1F, 6'h27, [6'h1A:6'h1D], [6'h21:6'h26], [6'h29:6'h3F]}))
    else $error("write to reserved register");
  wo_read_zero_a: assert property (rdCmd && cmdAddr inside {6'h0F, 6'h14, 6'h20, 6'h28}
    |=> rdData == 8'h00) else $error("write-only read not zero");
  ref_rsvd_bit_a: assert property (rdCmd && cmdAddr inside {6'h0C, 6'h0E} |=> !rdData[7])
    else $error("reserved bit set");
  info_rsvd_bits_a: assert property (rdCmd && cmdAddr == 6'h00 |=> (rdData & 8'h64) == 8'h00)
    else $error("reserved bits set");
  ref_readback_a: assert property (rdCmd && cmdAddr == lastAddr_r && lastAddr_r inside
    {6'h0C, 6'h0E} |=> rdData == {1'b0, lastData_r[6:0]}) else $error("read-back differs");

  cover property (cmdValid && cmdWrite);
  cover property (rdCmd && cmdAddr == 6'h12 ##1 rdValid);
  cover property (rdCmd && cmdAddr == lastAddr_r && lastAddr_r == 6'h0C);
endmodule

// File: dv/tb_top.sv
// Testbench joining controller and device through the link interface.
// Assumes each user request is answered within a few cycles.
`timescale 1ns/1ps
module tb_top;
  import smr_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        reqValid = 1'b0;
  logic        reqWrite = 1'b0;
  logic [5:0]  reqAddr = 6'h00;
  logic [7:0]  reqData = 8'h00;
  logic [15:0] oscCount = 16'h0000;
  logic        rowHammerBusy = 1'b0;
  logic        reqReady, reqReject, rspValid, rj, opSp, wrSp, write_latency_set_select, wrInv, rdInv;
  logic [2:0]  wl, rl, wr, caOdt, dqOdt;
  logic [6:0]  caRef, dqRef;
  logic [7:0]  rspData, q, loInv, hiInv, patA, patB;
  int          bad_count = 0;
  int          samples_checked = 0;

  smr_link_if link ();
  smr_controller smr_controller_inst (.core_clk(core_clk), .reset_n(reset_n), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady),
    .reqReject(reqReject), .rspValid(rspValid), .rspData(rspData), .link(link));
  // Identity values are arbitrary.
  smr_device #(.DEVICE_INFO_VALUE(8'hFF), .MAKER_CODE_VALUE(8'h3C)) smr_device_inst (
    .core_clk(core_clk), .reset_n(reset_n), .link(link), .oscCount(oscCount),
    .rowHammerBusy(rowHammerBusy), .operatingSetPoint(opSp), .writeSetPoint(wrSp),
    .writeLatencySetSelect(write_latency_set_select), .writeLatencyCode(wl), .readLatencyCode(rl),
    .writeRecoveryCode(wr), .writeInversionEnable(wrInv), .readInversionEnable(rdInv),
    .cmdBusTermination(caOdt), .dataTermination(dqOdt), .cmdReference(caRef),
    .dataReference(dqRef), .lowByteInvert(loInv), .highByteInvert(hiInv),
    .dqCalPatternA(patA), .dqCalPatternB(patB));
  smr_link_assertions smr_link_assertions_inst (.core_clk(core_clk), .reset_n(reset_n),
    .cmdValid(link.cmdValid), .cmdWrite(link.cmdWrite), .cmdAddr(link.cmdAddr),
    .cmdData(link.cmdData), .rdValid(link.rdValid), .rdData(link.rdData));

  always #2.5 core_clk = ~core_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
  endtask

  // One user request; the answer lands in q and rj.
  task automatic req(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqAddr <= a;
    reqData <= d;
    @(negedge core_clk);
    while (reqReady !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    check(reqReady, 1'h1);
    @(posedge core_clk);
    reqValid <= 1'b0;
    rj = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && rj !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      rj = reqReject;
      n++;
    end
    check(rspValid | rj, 1'h1);
    q = rspData;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    req(1'b0, a, 8'h00);
    check(q, e);
  endtask

  task automatic t_defaults();
    @(negedge core_clk);
    check({opSp, wrSp, write_latency_set_select}, 3'h0);
    check({wl, rl, wr}, 9'h000);
    check({wrInv, rdInv, caOdt, dqOdt}, 8'h00);
    check({caRef, dqRef}, 14'h26CD);
    rd(6'h0C, 8'h4D);
    rd(6'h0E, 8'h4D);
  endtask

  task automatic t_fields();
    req(1'b1, 6'h02, 8'h7F);
    req(1'b1, 6'h01, 8'h70);
    req(1'b1, 6'h03, 8'hC0);
    req(1'b1, 6'h0B, 8'h77);
    req(1'b1, 6'h0C, 8'h7F);
    req(1'b1, 6'h0E, 8'h25);
    @(negedge core_clk);
    check({write_latency_set_select, wl, rl, wr}, 10'h3FF);
    check({wrInv, rdInv, caOdt, dqOdt}, 8'hFF);
    check({caRef, dqRef}, 14'h3FA5);
    rd(6'h0E, 8'h25);
    rd(6'h02, 8'h00);
  endtask

  task automatic t_set_point();
    req(1'b1, 6'h0D, 8'h40);
    req(1'b1, 6'h0C, 8'h12);
    rd(6'h0C, 8'h12);
    check({opSp, wrSp, caRef}, 9'h0FF);
    req(1'b1, 6'h0D, 8'hC0);
    @(negedge core_clk);
    check({opSp, wrSp, caRef, wl}, 12'hC90);
    req(1'b1, 6'h0D, 8'h00);
    @(negedge core_clk);
    check({opSp, caRef, wl}, 11'h3FF);
  endtask

  task automatic t_masks();
    req(1'b1, 6'h0F, 8'h5A);
    req(1'b1, 6'h14, 8'hA5);
    req(1'b1, 6'h20, 8'h3C);
    req(1'b1, 6'h28, 8'hC3);
    @(negedge core_clk);
    check({loInv, hiInv}, 16'h5AA5);
    check({patA, patB}, 16'h3CC3);
    rd(6'h14, 8'h00);
    rd(6'h28, 8'h00);
  endtask

  task automatic t_readonly();
    @(posedge core_clk);
    oscCount <= 16'hBEEF;
    rowHammerBusy <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(6'h12, 8'hEF);
    rd(6'h13, 8'hBE);
    rd(6'h00, 8'h9B);
    rd(6'h05, 8'h3C);
    req(1'b1, 6'h12, 8'h00);
    check(rj, 1'h1);
    rd(6'h12, 8'hEF);
    req(1'b1, 6'h15, 8'h00);
    check(rj, 1'h1);
    rd(6'h15, 8'h00);
    req(1'b1, 6'h18, 8'hF0);
    rd(6'h18, 8'hF1);
  endtask

  initial begin
    do_reset();
    t_defaults();
    t_fields();
    t_set_point();
    t_masks();
    t_readonly();
    do_reset();
    t_defaults();
    stop_test();
  end

  initial begin
    #100000;
    bad_count++;
    stop_test();
  end
endmodule

// File: hdl/smr_controller.sv
// Controller end of the mode register link: turns user requests into read and write commands.
// Assumes the device answers a read one cycle after the command.
`timescale 1ns/1ps
module smr_controller
  import smr_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // User request
  input  wire logic       reqValid,
  input  wire logic       reqWrite,
  input  wire logic [5:0] reqAddr,
  input  wire logic [7:0] reqData,
  output logic            reqReady,
  output logic            reqReject,
  // User answer
  output logic            rspValid,
  output logic [7:0]      rspData,
  // Link to the device
  smr_link_if.ctrl        link
);

  typedef enum logic [1:0] {
    SMR_IDLE = 2'b01,
    SMR_WAIT = 2'b10
  } smr_state_e;

  typedef struct packed {
    smr_state_e state;
    logic       cmdValid;
    logic       cmdWrite;
    logic [5:0] cmdAddr;
    logic [7:0] cmdData;
    logic       reject;
    logic       rspValid;
    logic [7:0] rspData;
  } smr_ctrl_s;

  smr_ctrl_s st_r;
  smr_ctrl_s st_nxt;

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  always_comb begin
    st_nxt          = st_r;
    st_nxt.cmdValid = 1'b0;
    st_nxt.reject   = 1'b0;
    st_nxt.rspValid = 1'b0;
    case (st_r.state)
      SMR_IDLE: begin
        if (reqValid) begin
          // (R11) No writes to unwritable registers; (R16) writes to reserved numbers refused
          if (reqWrite && !(smr_access(reqAddr) == SMR_ACC_WO || smr_access(reqAddr) == SMR_ACC_RW)) begin
            st_nxt.reject = 1'b1;
          end else begin
            // (R6) Issue read or write command
            st_nxt.cmdValid = 1'b1;
            st_nxt.cmdWrite = reqWrite;
            st_nxt.cmdAddr  = reqAddr;
            // (R8) Reserved bits sent zero
            st_nxt.cmdData  = reqWrite ? (reqData & smr_used(reqAddr)) : 8'h00;
            st_nxt.state    = SMR_WAIT;
          end
        end
      end
      SMR_WAIT: begin
        if (!st_r.cmdWrite && !st_r.cmdValid) begin
          if (link.rdValid) begin
            st_nxt.rspValid = 1'b1;
            st_nxt.rspData  = link.rdData;
            st_nxt.state    = SMR_IDLE;
          end
        end else if (st_r.cmdWrite) begin
          st_nxt.rspValid = 1'b1;
          st_nxt.rspData  = 8'h00;
          st_nxt.state    = SMR_IDLE;
        end
      end
      default: st_nxt.state = SMR_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r       <= '0;
      st_r.state <= SMR_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reqReady      = (st_r.state == SMR_IDLE);
  assign reqReject     = st_r.reject;
  assign rspValid      = st_r.rspValid;
  assign rspData       = st_r.rspData;
  assign link.cmdValid = st_r.cmdValid;
  assign link.cmdWrite = st_r.cmdWrite;
  assign link.cmdAddr  = st_r.cmdAddr;
  assign link.cmdData  = st_r.cmdData;

endmodule

// File: hdl/smr_device.sv
// Device end of the mode register link: the mode register file with set point copies.
// Assumes the controller keeps reserved bits at zero and never writes reserved registers.
//
// Overview of operation
// (R1) Reset: set points 0, latencies and recovery zero
// (R2) Reset: inversion and termination disabled
// (R3) Reset: write latency set A selected
// (R4) Reset: command reference range 1, value 001101b
// (R5) Reset: data reference range 1, value 001101b
// (R6) Registers reached only by read/write commands
// (R7) Each register honours its access class
// (R8) Controller writes reserved bits as zero
// (R9) Reads return zero in reserved bits
// (R10) Reads of reserved/write-only registers undefined
// (R11) Controller never writes wholly reserved registers
// (R12) Writes to read-only registers change nothing
// (R13) Oscillator count readable at 12h and 13h
// (R14) Write-only invert masks at 0Fh, 14h
// (R15) Write-only calibration patterns at 20h, 28h
// (R16) Controller avoids reserved and do-not-use numbers (only writes are refused; reads of them are still issued)
// (R17) Set point copies: write select, operating select
// (R18) Six-bit address, eight data bits
`timescale 1ns/1ps
module smr_device
  import smr_pkg::*;
#(
  parameter logic [7:0] DEVICE_INFO_VALUE = 8'h00, // Arbitrary value.
  parameter logic [7:0] MAKER_CODE_VALUE  = 8'h5A, // Arbitrary value.
  parameter logic [7:0] REVISION_ONE      = 8'h01, // Arbitrary value.
  parameter logic [7:0] REVISION_TWO      = 8'h02, // Arbitrary value.
  parameter logic [7:0] SIZE_WIDTH_VALUE  = 8'h10, // Arbitrary value.
  parameter logic [7:0] REPAIR_VALUE      = 8'h00  // Arbitrary value.
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Link to the controller
  smr_link_if.dev          link,
  // Status from the device core
  input  wire logic [15:0] oscCount,
  input  wire logic        rowHammerBusy,
  // Operating configuration to the device core
  output logic             operatingSetPoint,
  output logic             writeSetPoint,
  output logic             writeLatencySetSelect,
  output logic [2:0]       writeLatencyCode,
  output logic [2:0]       readLatencyCode,
  output logic [2:0]       writeRecoveryCode,
  output logic             writeInversionEnable,
  output logic             readInversionEnable,
  output logic [2:0]       cmdBusTermination,
  output logic [2:0]       dataTermination,
  output logic [6:0]       cmdReference,
  output logic [6:0]       dataReference,
  output logic [7:0]       lowByteInvert,
  output logic [7:0]       highByteInvert,
  output logic [7:0]       dqCalPatternA,
  output logic [7:0]       dqCalPatternB
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0][7:0] featureOne;
    logic [1:0][7:0] latency;
    logic [1:0][7:0] ioConfig;
    logic [7:0]      refreshTraining;
    logic [7:0]      vendorTest;
    logic [7:0]      ioCal;
    logic [1:0][7:0] termination;
    logic [1:0][7:0] caReference;
    logic [7:0]      regControl;
    logic [1:0][7:0] dqReference;
    logic [7:0]      lowInvert;
    logic [7:0]      bankMask;
    logic [7:0]      segMask;
    logic [7:0]      highInvert;
    logic [1:0][7:0] termFeature;
    logic [7:0]      oscRunTime;
    logic [7:0]      rowHammer;
    logic [7:0]      patternA;
    logic [7:0]      patternB;
    logic [15:0]     oscSync1;
    logic [15:0]     oscSync2;
    logic [15:0]     oscSync3;
    logic [15:0]     oscStable;
    logic            rdValid;
    logic [7:0]      rdData;
  } smr_dev_s;

  smr_dev_s st_r;
  smr_dev_s st_nxt;

  logic       wrSel;
  logic       opSel;
  logic [7:0] wData;
  logic [7:0] rVal;
  logic       doWrite;

  assign wrSel = st_r.regControl[POS_WRITE_SET_POINT];
  assign opSel = st_r.regControl[POS_OPERATING_SET_POINT];

  // ****************************************************************
  // Command handling
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.oscSync1 = oscCount;
    st_nxt.oscSync2 = st_r.oscSync1;
    st_nxt.oscSync3 = st_r.oscSync2;
    // The count is taken only when two synchronised samples agree, so a word caught mid-change is never read.
    // A count that changes on every clock never settles and keeps its last stable value.
    if (st_r.oscSync2 == st_r.oscSync3) begin
      st_nxt.oscStable = st_r.oscSync2;
    end
    // (R18) Byte data, reserved bits dropped
    wData = link.cmdData & smr_used(link.cmdAddr);
    // (R6) Commands only; (R7) access class gate
    doWrite = link.cmdValid && link.cmdWrite &&
              (smr_access(link.cmdAddr) == SMR_ACC_WO || smr_access(link.cmdAddr) == SMR_ACC_RW);
    // (R12) Read-only writes ignored
    if (doWrite) begin
      case (link.cmdAddr)
        // (R17) Write select picks copy
        ADDR_DEVICE_FEATURE_ONE: st_nxt.featureOne[wrSel]  = wData;
        ADDR_LATENCY_CONFIG:     st_nxt.latency[wrSel]     = wData;
        ADDR_IO_CONFIG:          st_nxt.ioConfig[wrSel]    = wData;
        ADDR_REFRESH_TRAINING:   st_nxt.refreshTraining    = wData;
        ADDR_VENDOR_TEST_MODE:   st_nxt.vendorTest         = wData;
        ADDR_IO_CALIBRATION:     st_nxt.ioCal              = wData;
        ADDR_TERMINATION_CTRL:   st_nxt.termination[wrSel] = wData;
        ADDR_CA_REFERENCE:       st_nxt.caReference[wrSel] = wData;
        ADDR_REGISTER_CONTROL:   st_nxt.regControl         = wData;
        ADDR_DQ_REFERENCE:       st_nxt.dqReference[wrSel] = wData;
        // (R14) Invert masks written
        ADDR_LOW_INVERT_MASK:    st_nxt.lowInvert          = wData;
        ADDR_HIGH_INVERT_MASK:   st_nxt.highInvert         = wData;
        ADDR_BANK_REFRESH_MASK:  st_nxt.bankMask           = wData;
        ADDR_SEG_REFRESH_MASK:   st_nxt.segMask            = wData;
        ADDR_TERM_FEATURE_TWO:   st_nxt.termFeature[wrSel] = wData;
        ADDR_OSC_RUN_TIME:       st_nxt.oscRunTime         = wData;
        ADDR_ROW_HAMMER_CTRL:    st_nxt.rowHammer          = wData;
        // (R15) Calibration patterns written
        ADDR_DQ_CAL_PATTERN_A:   st_nxt.patternA           = wData;
        ADDR_DQ_CAL_PATTERN_B:   st_nxt.patternB           = wData;
        default: begin
        end
      endcase
    end
    // Readable registers; write-only and reserved ones answer zero.
    case (link.cmdAddr)
      ADDR_DEVICE_INFO:      rVal = DEVICE_INFO_VALUE;
      ADDR_REFRESH_TRAINING: rVal = st_r.refreshTraining;
      ADDR_MAKER_CODE:       rVal = MAKER_CODE_VALUE;
      ADDR_REVISION_ONE:     rVal = REVISION_ONE;
      ADDR_REVISION_TWO:     rVal = REVISION_TWO;
      ADDR_SIZE_WIDTH_INFO:  rVal = SIZE_WIDTH_VALUE;
      // (R17) Write select picks copy for reads
      ADDR_CA_REFERENCE:     rVal = st_r.caReference[wrSel];
      ADDR_DQ_REFERENCE:     rVal = st_r.dqReference[wrSel];
      // (R13) Oscillator count bytes
      ADDR_OSC_COUNT_LOW:    rVal = st_r.oscStable[7:0];
      ADDR_OSC_COUNT_HIGH:   rVal = st_r.oscStable[15:8];
      ADDR_ROW_HAMMER_CTRL:  rVal = {st_r.rowHammer[7:1], rowHammerBusy};
      ADDR_REPAIR_RESOURCES: rVal = REPAIR_VALUE;
      // (R10) Undefined reads give zero
      default:               rVal = 8'h00;
    endcase
    // (R6) Read answer one cycle later
    st_nxt.rdValid = link.cmdValid && !link.cmdWrite;
    // (R9) Reserved bits read zero
    st_nxt.rdData  = (link.cmdValid && !link.cmdWrite) ? (rVal & smr_used(link.cmdAddr)) : 8'h00;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
      // (R1) Set points and write recovery defaults
      st_r.regControl  <= RST_REGISTER_CONTROL;
      st_r.featureOne  <= {2{RST_FEATURE_ONE}};
      // (R3) Latency set A
      st_r.latency     <= {2{RST_LATENCY_CONFIG}};
      // (R2) Inversion, termination off
      st_r.ioConfig    <= {2{RST_IO_CONFIG}};
      st_r.termination <= {2{RST_TERMINATION}};
      // (R4) Command reference default
      st_r.caReference <= {2{RST_CA_REFERENCE}};
      // (R5) Data reference default
      st_r.dqReference <= {2{RST_DQ_REFERENCE}};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // (R17) Operate from operating copy
  assign operatingSetPoint     = opSel;
  assign writeSetPoint         = wrSel;
  assign writeLatencySetSelect = st_r.latency[opSel][POS_WRITE_LATENCY_SET];
  assign writeLatencyCode      = st_r.latency[opSel][5:3];
  assign readLatencyCode       = st_r.latency[opSel][2:0];
  assign writeRecoveryCode     = st_r.featureOne[opSel][6:4];
  assign writeInversionEnable  = st_r.ioConfig[opSel][7];
  assign readInversionEnable   = st_r.ioConfig[opSel][6];
  assign cmdBusTermination     = st_r.termination[opSel][6:4];
  assign dataTermination       = st_r.termination[opSel][2:0];
  assign cmdReference          = st_r.caReference[opSel][6:0];
  assign dataReference         = st_r.dqReference[opSel][6:0];
  assign lowByteInvert         = st_r.lowInvert;
  assign highByteInvert        = st_r.highInvert;
  assign dqCalPatternA         = st_r.patternA;
  assign dqCalPatternB         = st_r.patternB;
  assign link.rdValid          = st_r.rdValid;
  assign link.rdData           = st_r.rdData;

endmodule

// File: hdl/smr_link_if.sv
// Interface joining the controller end and the device end of the mode register link.
// Assumes both ends run on the same core clock; data is one byte per command.
`timescale 1ns/1ps
interface smr_link_if;
  logic       cmdValid;
  logic       cmdWrite;
  logic [5:0] cmdAddr;
  logic [7:0] cmdData;
  logic       rdValid;
  logic [7:0] rdData;

  modport ctrl (output cmdValid, output cmdWrite, output cmdAddr, output cmdData,
                input rdValid, input rdData);
  modport dev  (input cmdValid, input cmdWrite, input cmdAddr, input cmdData,
                output rdValid, output rdData);
endinterface

// File: hdl/smr_pkg.sv
// Package for the mode register file: register addresses, field positions, reset values.
// Assumes a single 200 MHz core clock shared by both ends of the mode register link.
package smr_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [5:0] ADDR_DEVICE_INFO        = 6'h00;
  localparam logic [5:0] ADDR_DEVICE_FEATURE_ONE = 6'h01;
  localparam logic [5:0] ADDR_LATENCY_CONFIG     = 6'h02;
  localparam logic [5:0] ADDR_IO_CONFIG          = 6'h03;
  localparam logic [5:0] ADDR_REFRESH_TRAINING   = 6'h04;
  localparam logic [5:0] ADDR_MAKER_CODE         = 6'h05;
  localparam logic [5:0] ADDR_REVISION_ONE       = 6'h06;
  localparam logic [5:0] ADDR_REVISION_TWO       = 6'h07;
  localparam logic [5:0] ADDR_SIZE_WIDTH_INFO    = 6'h08;
  localparam logic [5:0] ADDR_VENDOR_TEST_MODE   = 6'h09;
  localparam logic [5:0] ADDR_IO_CALIBRATION     = 6'h0A;
  localparam logic [5:0] ADDR_TERMINATION_CTRL   = 6'h0B;
  localparam logic [5:0] ADDR_CA_REFERENCE       = 6'h0C;
  localparam logic [5:0] ADDR_REGISTER_CONTROL   = 6'h0D;
  localparam logic [5:0] ADDR_DQ_REFERENCE       = 6'h0E;
  localparam logic [5:0] ADDR_LOW_INVERT_MASK    = 6'h0F;
  localparam logic [5:0] ADDR_BANK_REFRESH_MASK  = 6'h10;
  localparam logic [5:0] ADDR_SEG_REFRESH_MASK   = 6'h11;
  localparam logic [5:0] ADDR_OSC_COUNT_LOW      = 6'h12;
  localparam logic [5:0] ADDR_OSC_COUNT_HIGH     = 6'h13;
  localparam logic [5:0] ADDR_HIGH_INVERT_MASK   = 6'h14;
  localparam logic [5:0] ADDR_VENDOR_RESERVED    = 6'h15;
  localparam logic [5:0] ADDR_TERM_FEATURE_TWO   = 6'h16;
  localparam logic [5:0] ADDR_OSC_RUN_TIME       = 6'h17;
  localparam logic [5:0] ADDR_ROW_HAMMER_CTRL    = 6'h18;
  localparam logic [5:0] ADDR_REPAIR_RESOURCES   = 6'h19;
  localparam logic [5:0] ADDR_TEST_RESERVED_A    = 6'h1E;
  localparam logic [5:0] ADDR_FUTURE_RESERVED_1F = 6'h1F;
  localparam logic [5:0] ADDR_DQ_CAL_PATTERN_A   = 6'h20;
  localparam logic [5:0] ADDR_TEST_RESERVED_B    = 6'h27;
  localparam logic [5:0] ADDR_DQ_CAL_PATTERN_B   = 6'h28;

  // ****************************************************************
  // Reset values of the whole registers
  // ****************************************************************
  // Set point selects 00b in bits 7:6.
  localparam logic [7:0] RST_REGISTER_CONTROL = 8'h00;
  // Latency set A, write latency 000b, read latency 000b.
  localparam logic [7:0] RST_LATENCY_CONFIG   = 8'h00;
  // Write recovery 000b in bits 6:4.
  localparam logic [7:0] RST_FEATURE_ONE      = 8'h00;
  // Both inversion enables clear in bits 7:6.
  localparam logic [7:0] RST_IO_CONFIG        = 8'h00;
  // Both terminations off, bits 6:4 and 2:0.
  localparam logic [7:0] RST_TERMINATION      = 8'h00;
  // Range 1 in bit 6, value 001101b in bits 5:0.
  localparam logic [7:0] RST_CA_REFERENCE     = 8'h4D;
  localparam logic [7:0] RST_DQ_REFERENCE     = 8'h4D;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int POS_OPERATING_SET_POINT = 7;
  localparam int POS_WRITE_SET_POINT     = 6;
  localparam int POS_WRITE_LATENCY_SET   = 6;

  // Bits that hold data; zero marks a reserved bit position.
  localparam logic [7:0] USED_DEVICE_INFO  = 8'h9B;
  localparam logic [7:0] USED_TERMINATION  = 8'h77;
  localparam logic [7:0] USED_REFERENCE    = 8'h7F;
  localparam logic [7:0] USED_IO_CAL       = 8'h01;

  // Access classes.
  typedef enum logic [1:0] {
    SMR_ACC_NONE = 2'h0,
    SMR_ACC_RO   = 2'h1,
    SMR_ACC_WO   = 2'h2,
    SMR_ACC_RW   = 2'h3
  } smr_access_e;

  // Access class and used-bit mask for one address.
  function automatic smr_access_e smr_access(input logic [5:0] addr);
    case (addr)
      ADDR_DEVICE_INFO, ADDR_MAKER_CODE, ADDR_REVISION_ONE, ADDR_REVISION_TWO,
      ADDR_SIZE_WIDTH_INFO, ADDR_OSC_COUNT_LOW, ADDR_OSC_COUNT_HIGH,
      ADDR_REPAIR_RESOURCES: smr_access = SMR_ACC_RO;
      ADDR_REFRESH_TRAINING, ADDR_CA_REFERENCE, ADDR_DQ_REFERENCE,
      ADDR_ROW_HAMMER_CTRL: smr_access = SMR_ACC_RW;
      ADDR_DEVICE_FEATURE_ONE, ADDR_LATENCY_CONFIG, ADDR_IO_CONFIG,
      ADDR_VENDOR_TEST_MODE, ADDR_IO_CALIBRATION, ADDR_TERMINATION_CTRL,
      ADDR_REGISTER_CONTROL, ADDR_LOW_INVERT_MASK, ADDR_BANK_REFRESH_MASK,
      ADDR_SEG_REFRESH_MASK, ADDR_HIGH_INVERT_MASK, ADDR_TERM_FEATURE_TWO,
      ADDR_OSC_RUN_TIME, ADDR_DQ_CAL_PATTERN_A, ADDR_DQ_CAL_PATTERN_B: smr_access = SMR_ACC_WO;
      default: smr_access = SMR_ACC_NONE;
    endcase
  endfunction

  function automatic logic [7:0] smr_used(input logic [5:0] addr);
    case (addr)
      ADDR_DEVICE_INFO:                      smr_used = USED_DEVICE_INFO;
      ADDR_TERMINATION_CTRL:                 smr_used = USED_TERMINATION;
      ADDR_CA_REFERENCE, ADDR_DQ_REFERENCE:  smr_used = USED_REFERENCE;
      ADDR_IO_CALIBRATION:                   smr_used = USED_IO_CAL;
      default:                               smr_used = 8'hFF;
    endcase
  endfunction

endpackage
